//--- rtl/clock_control.sv
// Main clock selection, system prescaler, domain clock gating and start-up sequencer.
// Assumes oscillator and reset pins are asynchronous to clk, which is much faster than them.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "clk_ctl_cfg.svh"

module clock_control #(
  parameter logic [15:0] NORMAL_DELAY_EDGES = 16'(`RST_NORMAL_MS * `LP_OSC_KHZ),
  parameter logic [15:0] FAST_DELAY_EDGES   = 16'(`RST_FAST_MS * `LP_OSC_KHZ),
  parameter logic [7:0]  PROTECT_SIG        = 8'h5a
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       osc8_in,
  input  wire logic       osc128_in,
  input  wire logic       ext_clock_input,
  input  wire logic       reset_src_n,
  input  wire logic       ext_int_in,
  input  wire logic       fast_start_cfg,
  input  wire logic [7:0] factory_trim,
  input  wire logic       halt_core,
  input  wire logic       halt_periph,
  input  wire logic       halt_conv,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            internal_reset,
  output logic            core_clock,
  output logic            peripheral_clock,
  output logic            nvm_clock,
  output logic            converter_clock,
  output logic            wdt_clock,
  output logic            ext_int_wake,
  output logic      [7:0] oscillator_trim
);
  localparam int NSYNC = 5;

  clk_path_if path ();

  // Pin synchronisers: three stages, a level counts once stages two and three agree
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
  logic [NSYNC-1:0] pin_raw, pin_rise;
  logic             o8_f, lp_f, ext_f, rst_src_n_f, int_f;

  assign pin_raw = {ext_int_in, reset_src_n, ext_clock_input, osc128_in, osc8_in};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
      prev_q <= '0;
    end else begin
      s1_q   <= pin_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
      prev_q <= filt_q;
    end
  end

  assign pin_rise    = filt_q & ~prev_q;
  assign o8_f        = filt_q[0];
  assign lp_f        = filt_q[1];
  assign ext_f       = filt_q[2];
  assign rst_src_n_f = filt_q[3];
  assign int_f       = filt_q[4];

  // Clock path
  clk_source_switch u_switch (
    .clk     (clk),
    .arst_n  (arst_n),
    .src_lvl ({1'b0, ext_f, lp_f, o8_f}),
    .p       (path.sw)
  );

  sys_prescaler u_prescaler (
    .clk    (clk),
    .arst_n (arst_n),
    .p      (path.pre)
  );

  // Start-up sequencer
  clk_ctl_pkg::startup_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] dly_target_q;
  logic        int_reset_q;
  logic        dly_last, osc_last, cfg_last;

  assign dly_last = (st_q == clk_ctl_pkg::ST_DELAY) && pin_rise[1] &&
                    (cnt_q == dly_target_q - 16'h0001);
  assign osc_last = (st_q == clk_ctl_pkg::ST_OSC) && pin_rise[0] &&
                    (cnt_q == `OSC_SETTLE_CYC - 16'h0001);
  assign cfg_last = (st_q == clk_ctl_pkg::ST_CONFIG) && path.sys_rise &&
                    (cnt_q == `CONFIG_CYC - 16'h0001);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      clk_ctl_pkg::ST_HOLD: begin
        st_d  = clk_ctl_pkg::ST_DELAY;
        cnt_d = 16'h0000;
      end
      clk_ctl_pkg::ST_DELAY: begin
        // Supply level is not looked at; the full delay always elapses
        if (dly_last) begin
          st_d  = clk_ctl_pkg::ST_OSC;
          cnt_d = 16'h0000;
        end else if (pin_rise[1]) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      clk_ctl_pkg::ST_OSC: begin
        if (osc_last) begin
          st_d  = clk_ctl_pkg::ST_CONFIG;
          cnt_d = 16'h0000;
        end else if (pin_rise[0]) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      clk_ctl_pkg::ST_CONFIG: begin
        if (cfg_last) begin
          st_d = clk_ctl_pkg::ST_RUN;
        end else if (path.sys_rise) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      clk_ctl_pkg::ST_RUN: begin
      end
    endcase
    if (!rst_src_n_f) begin
      st_d  = clk_ctl_pkg::ST_HOLD;
      cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q        <= clk_ctl_pkg::ST_HOLD;
      cnt_q       <= 16'h0000;
      int_reset_q <= 1'b1;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      int_reset_q <= (st_d != clk_ctl_pkg::ST_RUN);
    end
  end

  // Strap is read only on leaving hold, so a change mid-count cannot shorten the delay
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_target_q <= NORMAL_DELAY_EDGES;
    end else if (st_q == clk_ctl_pkg::ST_HOLD && rst_src_n_f) begin
      dly_target_q <= fast_start_cfg ? FAST_DELAY_EDGES : NORMAL_DELAY_EDGES;
    end
  end

  // Register file
  clk_ctl_pkg::src_sel_t   sel_q;
  clk_ctl_pkg::div_code_t  prescale_q;
  logic [7:0]              trim_q;
  logic [2:0]              unlock_q;
  logic                    unlocked;
  logic                    wake_q;
  logic [7:0]              rdata_q;
  logic [7:0]              status;

  assign unlocked = (unlock_q != 3'h0);

  // Window counts instruction cycles, i.e. system clock edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_q <= 3'h0;
    end else if (int_reset_q) begin
      unlock_q <= 3'h0;
    end else if (reg_wr && reg_addr == `OFS_PROTECT && reg_wdata == PROTECT_SIG) begin
      unlock_q <= `PROTECT_WINDOW;
    end else if (unlocked && path.sys_rise) begin
      unlock_q <= unlock_q - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= `MAIN_SEL_RST;
    end else if (int_reset_q) begin
      sel_q <= `MAIN_SEL_RST;
    end else if (reg_wr && reg_addr == `OFS_MAIN_SEL && unlocked &&
                 reg_wdata[1:0] != `SEL_RESERVED) begin
      sel_q <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_q <= `PRESCALE_RST;
    end else if (int_reset_q) begin
      prescale_q <= `PRESCALE_RST;
    end else if (reg_wr && reg_addr == `OFS_PRESCALE && unlocked &&
                 reg_wdata[3:0] <= `PRESCALE_MAX) begin
      prescale_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_q <= 8'h00;
    end else if (osc_last && rst_src_n_f) begin
      trim_q <= factory_trim;
    end else if (!int_reset_q && reg_wr && reg_addr == `OFS_TRIM) begin
      trim_q <= reg_wdata;
    end
  end

  // Runs on clk, never on the gated peripheral clock; a new event beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_q <= 1'b0;
    end else if (pin_rise[4]) begin
      wake_q <= 1'b1;
    end else if (reg_wr && reg_addr == `OFS_STATUS && reg_wdata[`STAT_WAKE_BIT]) begin
      wake_q <= 1'b0;
    end
  end

  assign status = {2'b00, wake_q, unlocked, path.div_pend,
                   (path.cur_sel != sel_q), path.cur_sel};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_PRESCALE: rdata_q <= {4'h0, prescale_q};
        `OFS_MAIN_SEL: rdata_q <= {6'h00, sel_q};
        `OFS_TRIM:     rdata_q <= trim_q;
        `OFS_STATUS:   rdata_q <= status;
        default:       rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign path.req_sel  = sel_q;
  assign path.div_code = prescale_q;

  // Domain clock gating: enables move only while the system clock is low
  logic deliver;
  logic core_en_q, periph_en_q, conv_en_q;
  logic core_clk_q, periph_clk_q, nvm_clk_q, conv_clk_q, wdt_clk_q;

  assign deliver = (st_q == clk_ctl_pkg::ST_CONFIG) || (st_q == clk_ctl_pkg::ST_RUN);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_en_q   <= 1'b0;
      periph_en_q <= 1'b0;
      conv_en_q   <= 1'b0;
    end else if (!path.sys_clk) begin
      core_en_q   <= deliver && !halt_core;
      periph_en_q <= deliver && !halt_periph;
      conv_en_q   <= deliver && !halt_conv;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_clk_q   <= 1'b0;
      periph_clk_q <= 1'b0;
      nvm_clk_q    <= 1'b0;
      conv_clk_q   <= 1'b0;
      wdt_clk_q    <= 1'b0;
    end else begin
      core_clk_q   <= path.sys_clk & core_en_q;
      periph_clk_q <= path.sys_clk & periph_en_q;
      nvm_clk_q    <= path.sys_clk & core_en_q;
      conv_clk_q   <= path.sys_clk & conv_en_q;
      wdt_clk_q    <= lp_f;
    end
  end

  assign reg_rdata        = rdata_q;
  assign internal_reset   = int_reset_q;
  assign core_clock       = core_clk_q;
  assign peripheral_clock = periph_clk_q;
  assign nvm_clock        = nvm_clk_q;
  assign converter_clock  = conv_clk_q;
  assign wdt_clock        = wdt_clk_q;
  assign ext_int_wake     = wake_q;
  assign oscillator_trim  = trim_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  rst_at_once_a: assert property (!rst_src_n_f |=> int_reset_q &&
    st_q == clk_ctl_pkg::ST_HOLD) else $error("internal reset not asserted after reset source");
  rst_release_a: assert property ($fell(int_reset_q) |-> $past(cfg_last))
    else $error("internal reset released before configuration count ended");
  delay_full_a: assert property (st_q == clk_ctl_pkg::ST_DELAY && !dly_last &&
    rst_src_n_f |=> st_q == clk_ctl_pkg::ST_DELAY)
    else $error("reset delay left early");
  delay_end_a: assert property (dly_last && rst_src_n_f |=> st_q == clk_ctl_pkg::ST_OSC)
    else $error("reset delay did not end on its last edge");
  delay_pick_a: assert property (st_q == clk_ctl_pkg::ST_HOLD && rst_src_n_f
    |=> dly_target_q == ($past(fast_start_cfg) ? FAST_DELAY_EDGES : NORMAL_DELAY_EDGES))
    else $error("reset delay option not taken from strap");
  osc_gate_a: assert property (st_q == clk_ctl_pkg::ST_OSC |->
    !core_clk_q && !nvm_clk_q) else $error("clock delivered before oscillator settled");
  trim_load_a: assert property (osc_last && rst_src_n_f |=>
    trim_q == $past(factory_trim)) else $error("factory trim not loaded");
  reset_default_a: assert property (int_reset_q |=> sel_q == `SEL_INT8 &&
    prescale_q == `PRESCALE_RST)
    else $error("reset defaults not restored");
  protect_sel_a: assert property (reg_wr && reg_addr == `OFS_MAIN_SEL && !unlocked &&
    !int_reset_q |=> $stable(sel_q))
    else $error("source select changed without signature");
  prescale_rsv_a: assert property (reg_wr && reg_addr == `OFS_PRESCALE &&
    reg_wdata[3:0] > `PRESCALE_MAX && !int_reset_q |=> $stable(prescale_q))
    else $error("reserved prescale code taken");
  wdt_source_a: assert property (##1 wdt_clk_q == $past(lp_f))
    else $error("watchdog clock not from low-power oscillator");
  nvm_core_a: assert property (nvm_clk_q == core_clk_q)
    else $error("nvm clock apart from core clock");
  wake_set_a: assert property (pin_rise[4] |=> wake_q)
    else $error("external wake event lost");

  run_reached_c: cover property ($fell(int_reset_q));
  ext_switch_c: cover property (path.cur_sel == `SEL_EXT && path.main_rise);
  prescale_chg_c: cover property (!int_reset_q && $changed(prescale_q));
  conv_only_c: cover property (conv_clk_q && !core_en_q && !periph_en_q);
endmodule // clock_control

//--- common/clk_ctl_cfg.svh
// Offsets, reset values, field limits and timing counts of the clock control block.
// Assumes it is included by bare name after the package has been compiled.
`ifndef CLK_CTL_CFG_SVH
`define CLK_CTL_CFG_SVH

`define OFS_PRESCALE     6'h36
`define OFS_MAIN_SEL     6'h37
`define OFS_TRIM         6'h39
`define OFS_STATUS       6'h3a
`define OFS_PROTECT      6'h3c

`define PRESCALE_RST     4'h3
`define PRESCALE_MAX     4'h8
`define MAIN_SEL_RST     2'h0
`define SEL_INT8         2'h0
`define SEL_LP128        2'h1
`define SEL_EXT          2'h2
`define SEL_RESERVED     2'h3

`define STAT_WAKE_BIT    5
`define PROTECT_WINDOW   3'h4

`define RST_NORMAL_MS    64
`define RST_FAST_MS      8
`define LP_OSC_KHZ       128
`define OSC_SETTLE_CYC   16'h0006
`define CONFIG_CYC       16'h0015

`endif

//--- common/clk_ctl_pkg.sv
// Types shared by the clock control modules.
// Assumes nothing beyond a SystemVerilog compiler.
package clk_ctl_pkg;
  typedef enum logic [2:0] {ST_HOLD, ST_DELAY, ST_OSC, ST_CONFIG, ST_RUN} startup_state_e;
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT} switch_state_e;
  typedef logic [1:0] src_sel_t;
  typedef logic [3:0] div_code_t;
endpackage

//--- common/clk_path_if.sv
// Carries the main clock and system clock path between control, switch and prescaler.
// Assumes all signals live in the single clk domain.
`timescale 1ns/100ps
interface clk_path_if;
  clk_ctl_pkg::src_sel_t  req_sel;
  clk_ctl_pkg::src_sel_t  cur_sel;
  logic                   main_clk;
  logic                   main_rise;
  clk_ctl_pkg::div_code_t div_code;
  logic                   div_pend;
  logic                   sys_clk;
  logic                   sys_rise;

  modport sw  (input req_sel, output cur_sel, main_clk, main_rise);
  modport pre (input main_clk, main_rise, div_code, output div_pend, sys_clk, sys_rise);
  modport top (output req_sel, div_code,
               input cur_sel, main_clk, main_rise, div_pend, sys_clk, sys_rise);
endinterface // clk_path_if

//--- rtl/clk_source_switch.sv
// Glitch-free selector of the main clock among the filtered oscillator levels.
// Assumes src_lvl is already synchronised and req_sel never holds the reserved code.
`timescale 1ns/100ps
`include "clk_ctl_cfg.svh"
module clk_source_switch (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] src_lvl,
  clk_path_if.sw          p
);
  clk_ctl_pkg::switch_state_e st_q, st_d;
  clk_ctl_pkg::src_sel_t      cur_q, cur_d;
  logic                       main_q, main_d;
  logic                       rise_q;

  // Park low after the old source's high phase ends, then join the new source while it is low
  always_comb begin
    st_d  = st_q;
    cur_d = cur_q;
    unique case (st_q)
      clk_ctl_pkg::SW_IDLE: begin
        if (p.req_sel != cur_q && !main_q) begin
          st_d = clk_ctl_pkg::SW_WAIT;
        end
      end
      clk_ctl_pkg::SW_WAIT: begin
        if (!src_lvl[p.req_sel]) begin
          cur_d = p.req_sel;
          st_d  = clk_ctl_pkg::SW_IDLE;
        end
      end
    endcase
    main_d = (st_d == clk_ctl_pkg::SW_IDLE) ? src_lvl[cur_d] : 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= clk_ctl_pkg::SW_IDLE;
      cur_q  <= `SEL_INT8;
      main_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      main_q <= main_d;
      rise_q <= main_d & ~main_q;
    end
  end

  assign p.cur_sel   = cur_q;
  assign p.main_clk  = main_q;
  assign p.main_rise = rise_q;

  sw_no_glitch_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(cur_q) |-> !main_q && $past(!main_q))
    else $error("main clock not low across a source change");
endmodule // clk_source_switch

//--- rtl/sys_prescaler.sv
// Power-of-two divider of the main clock into the system clock.
// Assumes div_code holds only codes 0 to 8 and main_rise marks the first high cycle.
`timescale 1ns/100ps
`include "clk_ctl_cfg.svh"
module sys_prescaler (
  input  wire logic clk,
  input  wire logic arst_n,
  clk_path_if.pre   p
);
  clk_ctl_pkg::div_code_t code_q, code_d;
  logic [7:0]             hc_q, hc_d;
  logic [7:0]             half_m1;
  logic                   sys_q, sys_d;
  logic                   rise_q;

  // Counter state is internal only; software sees the requested code and the div_pend status flag
  always_comb begin
    code_d  = code_q;
    hc_d    = hc_q;
    sys_d   = sys_q;
    half_m1 = 8'h00;
    if (code_q == 4'h0) begin
      sys_d = p.main_clk;
      if (p.main_rise && p.div_code != code_q) begin
        code_d = p.div_code;
        hc_d   = 8'h00;
      end
    end else begin
      half_m1 = 8'((9'h001 << (code_q - 4'h1)) - 9'h001);
      if (p.main_rise) begin
        if (hc_q == half_m1) begin
          hc_d  = 8'h00;
          sys_d = ~sys_q;
          // Only at the start of a period, so no phase is cut short
          if (!sys_q && p.div_code != code_q) begin
            code_d = p.div_code;
          end
        end else begin
          hc_d = hc_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= `PRESCALE_RST;
      hc_q   <= 8'h00;
      sys_q  <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      code_q <= code_d;
      hc_q   <= hc_d;
      sys_q  <= sys_d;
      rise_q <= sys_d & ~sys_q;
    end
  end

  assign p.sys_clk  = sys_q;
  assign p.sys_rise = rise_q;
  assign p.div_pend = (code_q != p.div_code);

  pre_apply_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(code_q) |-> sys_q && !$past(sys_q) && $past(p.main_rise))
    else $error("prescale code applied away from a system clock rising edge");
endmodule // sys_prescaler

//--- sim/osc_model.sv
// Oscillator and external clock pins seen by the clock control block.
// Assumes a 10MHz sampling clock, so every level lasts several clk cycles.
`timescale 1ns/100ps
module osc_model (
  output logic osc8_in,
  output logic osc128_in,
  output logic ext_clock_input
);
  initial begin
    osc8_in = 1'b0;
    osc128_in = 1'b0;
    ext_clock_input = 1'b0;
  end
  // Slowed stand-ins so the 3-flop filter sees every level
  always #400 osc8_in = ~osc8_in;
  always #1600 osc128_in = ~osc128_in;
  // Fixed period, so no drift from one cycle to the next
  always #600 ext_clock_input = ~ext_clock_input;
endmodule // osc_model

//--- sim/main_clock_select_prescale_startup_test.sv
// Self-checking bench for the clock control block, random register traffic.
// Assumes osc_model drives the oscillator pins; delay counts shortened by parameters.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); err_count++; end end
module main_clock_select_prescale_startup_test;
  localparam logic [15:0] NORM = 16'h0008;
  localparam logic [15:0] FAST = 16'h0004;
  localparam logic [7:0]  SIG  = 8'h5a;
  logic clk, arst_n, osc8_in, osc128_in, ext_clock_input, reset_src_n, ext_int_in;
  logic fast_start_cfg, halt_core, halt_periph, halt_conv, reg_wr, reg_rd;
  logic [7:0] factory_trim, reg_wdata, reg_rdata, oscillator_trim, rd_v, v, sel, pre;
  logic [5:0] reg_addr;
  logic internal_reset, core_clock, peripheral_clock, nvm_clock, converter_clock;
  logic wdt_clock, ext_int_wake;
  int   err_count, n_compared, c_core, c_nvm, c_per, c_conv, c_128, c_wdt, n_norm, n_fast;

  clock_control #(.NORMAL_DELAY_EDGES(NORM), .FAST_DELAY_EDGES(FAST), .PROTECT_SIG(SIG))
  u_clock_control (.clk, .arst_n, .osc8_in, .osc128_in, .ext_clock_input, .reset_src_n,
    .ext_int_in, .fast_start_cfg, .factory_trim, .halt_core, .halt_periph, .halt_conv,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .internal_reset, .core_clock,
    .peripheral_clock, .nvm_clock, .converter_clock, .wdt_clock, .ext_int_wake,
    .oscillator_trim);
  osc_model u_osc_model (.osc8_in, .osc128_in, .ext_clock_input);

  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge core_clock) c_core++;
  always @(posedge nvm_clock) c_nvm++;
  always @(posedge peripheral_clock) c_per++;
  always @(posedge converter_clock) c_conv++;
  always @(posedge osc128_in) c_128++;
  always @(posedge wdt_clock) c_wdt++;

  // Reserved codes leave the stored value alone
  function automatic logic [7:0] keep(input logic [7:0] old, input logic [7:0] nw,
                                      input logic [7:0] lim);
    return (nw > lim) ? old : nw;
  endfunction

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [5:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
    `CHK(nm, e, rd_v)
  endtask

  task automatic pw(input logic [5:0] a, input logic [7:0] d);
    wr(6'h3c, SIG);
    wr(a, d);
  endtask

  task automatic wait_run();
    for (int i = 0; i < 20000 && internal_reset !== 1'b0; i++) @(posedge clk);
    #1 `CHK("startup done", 1'b0, internal_reset)
  endtask

  task automatic boot(input logic f, output int n128);
    @(posedge clk);
    fast_start_cfg <= f;
    reset_src_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1 `CHK("reset asserted", 1'b1, internal_reset)
    reset_src_n <= 1'b1;
    c_128 = 0;
    c_core = 0;
    wait_run();
    n128 = c_128;
    `CHK("config cycles", 1'b1, c_core >= 21)
    chk_rd(6'h36, 8'h03, "prescale rst");
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #6000000;
    err_count++;
    conclude();
  end

  initial begin
    void'($urandom(67));
    {arst_n, ext_int_in, fast_start_cfg, halt_core, halt_periph, halt_conv} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    reset_src_n = 1'b1;
    factory_trim = 8'($urandom);
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    wait_run();
    chk_rd(6'h36, 8'h03, "prescale rst");
    chk_rd(6'h37, 8'h00, "source rst");
    chk_rd(6'h39, factory_trim, "trim load");
    chk_rd(6'(6'h20 + $urandom % 20), 8'h00, "unmapped");
    $display("reset test done");
    wr(6'h37, 8'h02);
    chk_rd(6'h37, 8'h00, "unprotected source");
    sel = 8'h00;
    for (int i = 3; i >= 0; i--) begin
      pw(6'h37, {6'h00, 2'(i + 1)} ^ 8'h01);
      sel = keep(sel, {6'h00, 2'(i + 1)} ^ 8'h01, 8'h02);
      repeat (80) @(posedge clk);
      chk_rd(6'h37, sel, "source");
      // At most two system edges pass here, so the four-edge window is still open
      chk_rd(6'h3a, {4'h1, 2'h0, sel[1:0]}, "status");
    end
    c_wdt = 0;
    repeat (100) @(posedge clk);
    `CHK("wdt runs", 1'b1, c_wdt >= 2)
    $display("source test done");
    pre = 8'h03;
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h09 : 8'($urandom % 9);
      pw(6'h36, v);
      pre = keep(pre, v, 8'h08);
      chk_rd(6'h36, pre, "prescale");
    end
    for (int k = 0; k < 3; k++) begin
      pw(6'h36, 8'(k));
      // Old setting may be divide by 256, whose period must finish first
      repeat (2200) @(posedge clk);
      c_core = 0;
      repeat (256) @(posedge clk);
      `CHK("division", 1'b1, c_core inside {[(32 >> k) - 1 : (32 >> k) + 1]})
    end
    wr(6'h3c, SIG);
    repeat (200) @(posedge clk);
    wr(6'h36, 8'h05);
    chk_rd(6'h36, 8'h02, "late write");
    $display("prescale test done");
    @(posedge clk);
    halt_core <= 1'b1;
    halt_periph <= 1'b1;
    ext_int_in <= 1'b1;
    repeat (20) @(posedge clk);
    {c_core, c_nvm, c_per, c_conv} = '0;
    repeat (200) @(posedge clk);
    `CHK("halted", 0, c_core + c_nvm + c_per)
    `CHK("converter runs", 1'b1, c_conv > 0)
    `CHK("wake", 1'b1, ext_int_wake)
    ext_int_in <= 1'b0;
    wr(6'h3a, 8'h20);
    chk_rd(6'h3a, 8'h00, "wake cleared");
    halt_core <= 1'b0;
    halt_periph <= 1'b0;
    halt_conv <= 1'b1;
    repeat (20) @(posedge clk);
    {c_core, c_nvm, c_per, c_conv} = '0;
    repeat (200) @(posedge clk);
    `CHK("converter halted", 1'b1, c_conv == 0 && c_core > 0 && c_nvm == c_core)
    $display("domain test done");
    boot(1'b0, n_norm);
    boot(1'b1, n_fast);
    `CHK("normal delay", 1'b1, n_norm >= int'(NORM))
    `CHK("fast delay", 1'b1, n_fast >= int'(FAST) && n_fast < n_norm)
    $display("startup test done");
    conclude();
  end
endmodule // main_clock_select_prescale_startup_test
